/* verilog/cmf_pkg.sv */
// Purpose: constants and types for the four-queue cell multiplexing FIFO
// Assumes: one system clock; all cell-bus pins are synchronous to it
`default_nettype none

package cmf_pkg;
  localparam int         NQ           = 4;
  localparam int         BW           = 9;
  localparam int         DEPTH        = 128;
  localparam int         PW           = 7;
  localparam logic [7:0] DEPTH_CNT    = 8'h80;
  localparam logic [7:0] CELL_LEN_RST = 8'h35;
  localparam logic [7:0] DEL_POS      = 8'h04;
  localparam logic [7:0] INS_POS      = 8'h05;
  localparam logic [8:0] FILL_BYTE    = 9'h000;
  localparam int         AW           = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_FILL     = 8'h08;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } cmf_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cmf_axi_rsp_t;

  typedef enum logic {OUT_IDLE, OUT_SEND} cmf_out_state_t;
endpackage : cmf_pkg

`default_nettype wire

/* verilog/cmf_top.sv */
// Purpose: four byte-wide cell queues merged onto one 9/18-bit output bus
// Assumes: cell-bus agents and mode pins run on CLK_SYS_I; no synchronisers needed
// Notes: mode pins must be stable while cells are in flight
`default_nettype none

module cmf_top (
  input  wire logic                    CLK_SYS_I,              // system clock
  input  wire logic                    RST_N_I,                // async reset, low
  input  wire cmf_pkg::cmf_axi_req_t   AXI_REQ_I,              // register bus request
  output cmf_pkg::cmf_axi_rsp_t        AXI_RSP_O,              // register bus response
  input  wire logic                    DIR_TX_I,               // 0 receive, 1 transmit
  input  wire logic                    MASTER_SEL_I,           // 1 master, 0 slave
  input  wire logic                    ROT_EN_I,               // rotation enable
  input  wire logic                    BYTE_ADJUST_I,          // byte insert/delete
  input  wire logic                    BYTE_ORDER_FLIP_I,      // first byte high
  input  wire logic                    OUT_WIDTH_SELECT_I,     // 1 selects 9-bit bus
  input  wire logic                    STAT_EN_N_I,            // status pin enable, low
  input  wire logic                    QBUS_DRIVE_EN_I,        // output bus drive
  input  wire logic [3:0][8:0]         IN_DATA_I,              // per-queue input bytes
  input  wire logic [3:0]              IN_CELL_BEGIN_I,        // per-queue cell start
  input  wire logic [3:0]              IN_SIDE_ENABLE_I,       // enable pin in
  output logic      [3:0]              IN_SIDE_ENABLE_O,       // enable pin out
  output logic      [3:0]              IN_SIDE_ENABLE_OE_O,    // enable pin drive
  input  wire logic [3:0]              IN_CELL_AVAIL_I,        // cell avail pin in
  output logic      [3:0]              IN_CELL_AVAIL_O,        // cell avail pin out
  output logic      [3:0]              IN_CELL_AVAIL_OE_O,     // cell avail pin drive
  output logic      [17:0]             OUT_BUS_O,              // output data word
  output logic                         OUT_BUS_OE_O,           // output data drive
  output logic                         OUT_CELL_BEGIN_O,       // first word on bus
  input  wire logic                    OUT_SIDE_ENABLE_I,      // word enable in
  output logic                         OUT_SIDE_ENABLE_O,      // word enable out
  output logic                         OUT_SIDE_ENABLE_OE_O,   // word enable drive
  input  wire logic                    OUT_CELL_AVAIL_I,       // out avail pin in
  output logic                         OUT_CELL_AVAIL_O,       // out avail pin out
  output logic                         OUT_CELL_AVAIL_OE_O,    // out avail drive
  input  wire logic                    MUX_LOAD_I,             // mux load in
  output logic                         MUX_LOAD_O,             // mux load out
  output logic                         MUX_LOAD_OE_O,          // mux load drive
  input  wire logic                    FIFO_SEL_LOW_I,         // select lsb in
  output logic                         FIFO_SEL_LOW_O,         // select lsb out
  output logic                         FIFO_SEL_LOW_OE_O,      // select lsb drive
  input  wire logic                    FIFO_SEL_HIGH_I,        // select msb in
  output logic                         FIFO_SEL_HIGH_O,        // select msb out
  output logic                         FIFO_SEL_HIGH_OE_O,     // select msb drive
  input  wire logic [3:0]              PER_QUEUE_CELL_READY_I, // cell ready pins in
  output logic      [3:0]              PER_QUEUE_CELL_READY_O, // cell ready pins out
  output logic      [3:0]              PER_QUEUE_CELL_READY_OE_O, // cell ready drive
  input  wire logic                    CELL_END_WARN_I,        // warn pin in
  output logic                         CELL_END_WARN_O,        // warn pin out
  output logic                         CELL_END_WARN_OE_O      // warn pin drive
);

  localparam int NQ = cmf_pkg::NQ;

  logic [8:0]  mem_q [NQ][cmf_pkg::DEPTH];
  logic [6:0]  wr_ptr_q [NQ];
  logic [6:0]  wr_ptr_d [NQ];
  logic [6:0]  rd_ptr_q [NQ];
  logic [6:0]  rd_ptr_d [NQ];
  logic [7:0]  used_q   [NQ];
  logic [7:0]  used_d   [NQ];
  logic [7:0]  cells_q  [NQ];
  logic [7:0]  cells_d  [NQ];
  logic [7:0]  in_cnt_q [NQ];
  logic [7:0]  in_cnt_d [NQ];
  logic [7:0]  in_pos   [NQ];
  logic [3:0]  in_busy_q;
  logic [3:0]  in_busy_d;
  logic [3:0]  in_en_q;
  logic [3:0]  in_en_d;
  logic [3:0]  in_strobe;
  logic [3:0]  in_start;
  logic [3:0]  in_take;
  logic [3:0]  in_last;
  logic [3:0]  wr_en;
  logic [3:0]  room;
  logic [3:0]  rel;
  logic [3:0]  cell_rdy;

  cmf_pkg::cmf_out_state_t ost_q;
  cmf_pkg::cmf_out_state_t ost_d;
  logic [1:0]  cur_q;
  logic [1:0]  cur_d;
  logic [7:0]  widx_q;
  logic [7:0]  widx_d;
  logic [17:0] obus_q;
  logic [17:0] obus_d;
  logic        obeg_q;
  logic        obeg_d;
  logic        warn_q;
  logic        warn_d;
  logic        out_xfer;
  logic        out_done;
  logic [1:0]  sel_q;
  logic [1:0]  sel_d;
  logic        load_q;
  logic        load_d;

  logic        dir_rx;
  logic        w18;
  logic        del_en;
  logic        ins_en;
  logic        stat_drive;
  logic [7:0]  stored_len;
  logic [7:0]  out_bytes;
  logic [7:0]  n_words;
  logic [4:0]  strap_q;
  logic [4:0]  strap_d;

  logic [7:0]  cell_len_q;
  logic [7:0]  cell_len_d;
  logic        aw_ok_q;
  logic        aw_ok_d;
  logic [7:0]  aw_addr_q;
  logic [7:0]  aw_addr_d;
  logic        w_ok_q;
  logic        w_ok_d;
  logic [7:0]  w_byte_q;
  logic [7:0]  w_byte_d;
  logic        w_lane0_q;
  logic        w_lane0_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;

  assign dir_rx     = !DIR_TX_I;
  assign w18        = !OUT_WIDTH_SELECT_I;
  // deletion applies when the device transmits cells, at either bus width, insertion when it receives them
  assign del_en     = BYTE_ADJUST_I && DIR_TX_I;
  assign ins_en     = BYTE_ADJUST_I && !DIR_TX_I;
  assign stat_drive = RST_N_I && !STAT_EN_N_I;
  assign stored_len = cell_len_q - {7'h00, del_en};
  assign out_bytes  = stored_len + {7'h00, ins_en};
  assign n_words    = w18 ? ((out_bytes + 8'h01) >> 1) : out_bytes;

  // one output byte of the cell at the head of queue q; k counts output bytes
  function automatic logic [8:0] byte_at(input logic [1:0] q, input logic [7:0] k);
    logic [7:0] src;
    logic [6:0] a;
    src     = (ins_en && k > cmf_pkg::INS_POS) ? k - 8'h01 : k;
    a       = rd_ptr_q[q] + src[6:0];
    byte_at = cmf_pkg::FILL_BYTE;
    if (k < out_bytes && !(ins_en && k == cmf_pkg::INS_POS))
      byte_at = mem_q[q][a];
  endfunction : byte_at

  function automatic logic [17:0] word_at(input logic [1:0] q, input logic [7:0] i);
    logic [7:0] k;
    logic [8:0] b0;
    logic [8:0] b1;
    k  = w18 ? {i[6:0], 1'b0} : i;
    b0 = byte_at(q, k);
    b1 = byte_at(q, k + 8'h01);
    if (!w18)
      word_at = {cmf_pkg::FILL_BYTE, b0};
    else if (BYTE_ORDER_FLIP_I)
      word_at = {b0, b1};
    else
      word_at = {b1, b0};
  endfunction : word_at

  // input side: cell framing, queue pointers and the receive-mode enables
  always_comb
  begin
    for (int q = 0; q < NQ; q++)
    begin
      room[q]      = (cmf_pkg::DEPTH_CNT - used_q[q]) >= cell_len_q;
      in_pos[q]    = in_busy_q[q] ? in_cnt_q[q] : 8'h00;
      in_strobe[q] = dir_rx ? in_en_q[q] : IN_SIDE_ENABLE_I[q];
      in_start[q]  = !in_busy_q[q] && in_strobe[q] && IN_CELL_BEGIN_I[q]
                     && (dir_rx ? IN_CELL_AVAIL_I[q] : room[q]);
      // cell begin is not looked at once a cell is under way
      in_take[q]   = in_start[q] || (in_busy_q[q] && in_strobe[q]);
      wr_en[q]     = in_take[q] && !(del_en && in_pos[q] == cmf_pkg::DEL_POS);
      in_last[q]   = in_take[q] && (in_pos[q] + 8'h01 == cell_len_q);
      in_busy_d[q] = in_take[q] ? !in_last[q] : in_busy_q[q];
      in_cnt_d[q]  = in_take[q] ? in_pos[q] + 8'h01 : in_cnt_q[q];
      wr_ptr_d[q]  = wr_en[q] ? wr_ptr_q[q] + 7'h01 : wr_ptr_q[q];
      rel[q]       = out_done && (cur_q == 2'(q));
      rd_ptr_d[q]  = rel[q] ? rd_ptr_q[q] + stored_len[6:0] : rd_ptr_q[q];
      used_d[q]    = used_q[q] + {7'h00, wr_en[q]} - (rel[q] ? stored_len : 8'h00);
      cells_d[q]   = cells_q[q] + {7'h00, in_last[q]} - {7'h00, rel[q]};
      cell_rdy[q]  = cells_q[q] != 8'h00;
      // hold the enable through a cell; open a new one only with room for it
      in_en_d[q]   = dir_rx && (in_busy_d[q] || (IN_CELL_AVAIL_I[q]
                     && ((cmf_pkg::DEPTH_CNT - used_d[q]) >= cell_len_q)));
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      for (int q = 0; q < NQ; q++)
      begin
        for (int a = 0; a < cmf_pkg::DEPTH; a++)
          mem_q[q][a] <= cmf_pkg::FILL_BYTE;
        wr_ptr_q[q] <= 7'h00;
        rd_ptr_q[q] <= 7'h00;
        used_q[q]   <= 8'h00;
        cells_q[q]  <= 8'h00;
        in_cnt_q[q] <= 8'h00;
      end
      in_busy_q <= 4'h0;
      in_en_q   <= 4'h0;
    end
    else
    begin
      for (int q = 0; q < NQ; q++)
      begin
        if (wr_en[q])
          mem_q[q][wr_ptr_q[q]] <= IN_DATA_I[q];
        wr_ptr_q[q] <= wr_ptr_d[q];
        rd_ptr_q[q] <= rd_ptr_d[q];
        used_q[q]   <= used_d[q];
        cells_q[q]  <= cells_d[q];
        in_cnt_q[q] <= in_cnt_d[q];
      end
      in_busy_q <= in_busy_d;
      in_en_q   <= in_en_d;
    end
  end

  // output side: one whole cell per visit, word by word
  assign out_xfer = (ost_q == cmf_pkg::OUT_SEND) && (dir_rx ? OUT_SIDE_ENABLE_I : 1'b1);

  always_comb
  begin
    ost_d    = ost_q;
    cur_d    = cur_q;
    widx_d   = widx_q;
    obus_d   = obus_q;
    obeg_d   = obeg_q;
    warn_d   = warn_q;
    out_done = 1'b0;
    case (ost_q)
      cmf_pkg::OUT_IDLE:
      begin
        if (cells_q[sel_q] != 8'h00 && (dir_rx || OUT_CELL_AVAIL_I))
        begin
          ost_d  = cmf_pkg::OUT_SEND;
          cur_d  = sel_q;
          widx_d = 8'h00;
          obus_d = word_at(sel_q, 8'h00);
          obeg_d = 1'b1;
          warn_d = n_words <= 8'h02;
        end
      end
      cmf_pkg::OUT_SEND:
      begin
        if (out_xfer)
        begin
          if (widx_q + 8'h01 == n_words)
          begin
            out_done = 1'b1;
            ost_d    = cmf_pkg::OUT_IDLE;
            obeg_d   = 1'b0;
            warn_d   = 1'b0;
          end
          else
          begin
            widx_d = widx_q + 8'h01;
            obus_d = word_at(cur_q, widx_d);
            obeg_d = 1'b0;
            // high from the penultimate word until the final one is taken
            warn_d = (widx_q + 8'h03) >= n_words;
          end
        end
      end
      default:
        ost_d = cmf_pkg::OUT_IDLE;
    endcase
  end

  // queue selection: own sequencer or externally loaded address
  always_comb
  begin
    sel_d  = sel_q;
    load_d = 1'b0;
    if (ROT_EN_I)
    begin
      if (out_done)
      begin
        sel_d  = sel_q + 2'h1;
        load_d = MASTER_SEL_I;
      end
    end
    else if (MUX_LOAD_I)
      sel_d = {FIFO_SEL_HIGH_I, FIFO_SEL_LOW_I};
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ost_q  <= cmf_pkg::OUT_IDLE;
      cur_q  <= 2'h0;
      widx_q <= 8'h00;
      obus_q <= 18'h00000;
      obeg_q <= 1'b0;
      warn_q <= 1'b0;
      sel_q  <= 2'h0;
      load_q <= 1'b0;
    end
    else
    begin
      ost_q  <= ost_d;
      cur_q  <= cur_d;
      widx_q <= widx_d;
      obus_q <= obus_d;
      obeg_q <= obeg_d;
      warn_q <= warn_d;
      sel_q  <= sel_d;
      load_q <= load_d;
    end
  end

  // cell-size straps are only meaningful while reset is held, so no reset here
  assign strap_d = (!RST_N_I && STAT_EN_N_I) ? {CELL_END_WARN_I, PER_QUEUE_CELL_READY_I}
                                             : strap_q;

  always_ff @(posedge CLK_SYS_I)
  begin
    strap_q <= strap_d;
  end

  // register slave; one write and one read at a time
  always_comb
  begin
    aw_ok_d    = aw_ok_q;
    aw_addr_d  = aw_addr_q;
    w_ok_d     = w_ok_q;
    w_byte_d   = w_byte_q;
    w_lane0_d  = w_lane0_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    cell_len_d = cell_len_q;
    if (AXI_REQ_I.awvalid && AXI_RSP_O.awready)
    begin
      aw_ok_d   = 1'b1;
      aw_addr_d = AXI_REQ_I.awaddr;
    end
    if (AXI_REQ_I.wvalid && AXI_RSP_O.wready)
    begin
      w_ok_d    = 1'b1;
      w_byte_d  = AXI_REQ_I.wdata[7:0];
      w_lane0_d = AXI_REQ_I.wstrb[0];
    end
    if (aw_ok_q && w_ok_q)
    begin
      aw_ok_d  = 1'b0;
      w_ok_d   = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = cmf_pkg::RESP_OKAY;
      if (aw_addr_q == cmf_pkg::REG_CTRL)
      begin
        if (w_lane0_q)
          cell_len_d = w_byte_q;
      end
      else if (aw_addr_q != cmf_pkg::REG_STATUS && aw_addr_q != cmf_pkg::REG_FILL)
        bresp_d = cmf_pkg::RESP_DECERR;
    end
    if (bvalid_q && AXI_REQ_I.bready)
      bvalid_d = 1'b0;
    if (rvalid_q && AXI_REQ_I.rready)
      rvalid_d = 1'b0;
    if (AXI_REQ_I.arvalid && AXI_RSP_O.arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = cmf_pkg::RESP_OKAY;
      case (AXI_REQ_I.araddr)
        cmf_pkg::REG_CTRL:
          rdata_d = {24'h000000, cell_len_q};
        cmf_pkg::REG_STATUS:
          rdata_d = {19'h00000, strap_q, 3'h0, ost_q == cmf_pkg::OUT_SEND, cell_rdy};
        cmf_pkg::REG_FILL:
          rdata_d = {used_q[3], used_q[2], used_q[1], used_q[0]};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = cmf_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      aw_ok_q    <= 1'b0;
      aw_addr_q  <= 8'h00;
      w_ok_q     <= 1'b0;
      w_byte_q   <= 8'h00;
      w_lane0_q  <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'h0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h00000000;
      rresp_q    <= 2'h0;
      cell_len_q <= cmf_pkg::CELL_LEN_RST;
    end
    else
    begin
      aw_ok_q    <= aw_ok_d;
      aw_addr_q  <= aw_addr_d;
      w_ok_q     <= w_ok_d;
      w_byte_q   <= w_byte_d;
      w_lane0_q  <= w_lane0_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      cell_len_q <= cell_len_d;
    end
  end

  always_comb
  begin
    AXI_RSP_O.awready = !aw_ok_q && !bvalid_q;
    AXI_RSP_O.wready  = !w_ok_q && !bvalid_q;
    AXI_RSP_O.bvalid  = bvalid_q;
    AXI_RSP_O.bresp   = bresp_q;
    AXI_RSP_O.arready = !rvalid_q;
    AXI_RSP_O.rvalid  = rvalid_q;
    AXI_RSP_O.rdata   = rdata_q;
    AXI_RSP_O.rresp   = rresp_q;
  end

  // pin directions follow the mode inputs
  assign IN_SIDE_ENABLE_O          = in_en_q;
  assign IN_SIDE_ENABLE_OE_O       = {4{dir_rx}};
  assign IN_CELL_AVAIL_O           = room;
  assign IN_CELL_AVAIL_OE_O        = {4{!dir_rx}};
  assign OUT_BUS_O                 = obus_q;
  assign OUT_BUS_OE_O              = QBUS_DRIVE_EN_I;
  assign OUT_CELL_BEGIN_O          = obeg_q;
  assign OUT_SIDE_ENABLE_O         = ost_q == cmf_pkg::OUT_SEND;
  assign OUT_SIDE_ENABLE_OE_O      = !dir_rx;
  assign OUT_CELL_AVAIL_O          = cell_rdy[sel_q] || (ost_q == cmf_pkg::OUT_SEND);
  assign OUT_CELL_AVAIL_OE_O       = dir_rx;
  assign MUX_LOAD_O                = load_q;
  assign MUX_LOAD_OE_O             = ROT_EN_I && MASTER_SEL_I;
  assign FIFO_SEL_LOW_O            = sel_q[0];
  assign FIFO_SEL_LOW_OE_O         = ROT_EN_I;
  assign FIFO_SEL_HIGH_O           = sel_q[1];
  assign FIFO_SEL_HIGH_OE_O        = ROT_EN_I;
  assign PER_QUEUE_CELL_READY_O    = cell_rdy;
  assign PER_QUEUE_CELL_READY_OE_O = {4{stat_drive}};
  assign CELL_END_WARN_O           = warn_q;
  assign CELL_END_WARN_OE_O        = stat_drive;

endmodule : cmf_top

`default_nettype wire

/* tb/cmf_checker.sv */
// Purpose: pin direction and cell timing checks on cmf_top
// Assumes: one clock, reset active low
// Notes: sees top ports only
`default_nettype none
module cmf_checker (
  input wire logic       CLK_SYS_I,              // clock
  input wire logic       RST_N_I,                // reset
  input wire logic       DIR_TX_I,               // mode
  input wire logic       MASTER_SEL_I,           // master
  input wire logic       ROT_EN_I,               // rotation
  input wire logic       STAT_EN_N_I,            // status
  input wire logic       QBUS_DRIVE_EN_I,        // bus drive
  input wire logic       OUT_SIDE_ENABLE_I,      // word enable
  input wire logic [3:0] IN_SIDE_ENABLE_OE_O,    // enable oe
  input wire logic       OUT_BUS_OE_O,           // bus oe
  input wire logic       OUT_CELL_BEGIN_O,       // first word
  input wire logic       OUT_SIDE_ENABLE_OE_O,   // enable oe
  input wire logic       OUT_SIDE_ENABLE_O,      // enable out
  input wire logic       MUX_LOAD_O,             // load
  input wire logic       MUX_LOAD_OE_O,          // load oe
  input wire logic       FIFO_SEL_LOW_OE_O,      // select oe
  input wire logic [3:0] PER_QUEUE_CELL_READY_O, // ready
  input wire logic       CELL_END_WARN_O,        // warn
  input wire logic       CELL_END_WARN_OE_O      // warn oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  bus_drive_a: assert property (OUT_BUS_OE_O == QBUS_DRIVE_EN_I)
    else $error("bus oe wrong");
  in_en_dir_a: assert property (IN_SIDE_ENABLE_OE_O == {4{!DIR_TX_I}})
    else $error("in enable dir wrong");
  out_en_dir_a: assert property (OUT_SIDE_ENABLE_OE_O == DIR_TX_I)
    else $error("out enable dir wrong");
  sel_dir_a: assert property (FIFO_SEL_LOW_OE_O == ROT_EN_I)
    else $error("select dir wrong");
  load_dir_a: assert property (MUX_LOAD_OE_O == (ROT_EN_I && MASTER_SEL_I))
    else $error("load dir wrong");
  stat_dir_a: assert property (CELL_END_WARN_OE_O == !STAT_EN_N_I)
    else $error("warn oe wrong");
  load_pulse_a: assert property (MUX_LOAD_O |=> !MUX_LOAD_O)
    else $error("load pulse too long");
  begin_once_a: assert property (OUT_CELL_BEGIN_O && OUT_SIDE_ENABLE_I && !DIR_TX_I
    |=> !OUT_CELL_BEGIN_O) else $error("begin past first word");
  warn_drop_a: assert property ($fell(CELL_END_WARN_O) && !DIR_TX_I
    |-> $past(OUT_SIDE_ENABLE_I)) else $error("warn fell early");
  reset_clear_a: assert property ($rose(RST_N_I) |-> PER_QUEUE_CELL_READY_O == 4'h0
    && !OUT_CELL_BEGIN_O) else $error("reset left state");
  load_after_a: assert property ($fell(OUT_SIDE_ENABLE_O) && ROT_EN_I && MASTER_SEL_I
    |-> MUX_LOAD_O) else $error("no load pulse");
endmodule : cmf_checker
bind cmf_top cmf_checker u_chk (.*);
`default_nettype wire

/* tb/cmf_cell_agent.sv */
// Purpose: receive- and transmit-mode cell sender for the four input queues
// Assumes: enable comes from the device (receive) or the bench (transmit)
// Notes: idle data lines churn so a stale byte never looks valid
`default_nettype none
module cmf_cell_agent (
  input  wire logic            clk_i,   // clock
  input  wire logic            rst_n_i, // reset
  input  wire logic            go_i,    // start cell
  input  wire logic [1:0]      q_i,     // queue
  input  wire logic [8:0]      base_i,  // first byte
  input  wire logic [7:0]      len_i,   // bytes
  input  wire logic [3:0]      en_i,    // enables
  output logic      [3:0][8:0] data_o,  // bytes
  output logic      [3:0]      begin_o, // cell start
  output logic      [3:0]      avail_o  // cell ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic [1:0] q_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      data_o  <= '0;
      begin_o <= 4'h0;
      avail_o <= 4'h0;
      cnt_q   <= 8'h00;
      q_q     <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        if (!avail_o[i])
          data_o[i] <= ~data_o[i];
      if (go_i)
      begin
        avail_o[q_i] <= 1'b1;
        begin_o[q_i] <= 1'b1;
        data_o[q_i]  <= base_i;
        cnt_q        <= 8'h00;
        q_q          <= q_i;
      end
      else if (avail_o[q_q] && en_i[q_q])
      begin
        begin_o[q_q] <= 1'b0;
        data_o[q_q]  <= data_o[q_q] + 9'h001;
        cnt_q        <= cnt_q + 8'h01;
        if (cnt_q == len_i - 8'h01)
          avail_o[q_q] <= 1'b0;
      end
    end
endmodule : cmf_cell_agent
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for cmf_top
// Assumes: output words taken every cycle
// Notes: cells shortened through the length register to keep runs brief
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  int num_errors = 0, total_checks = 0, cycles = 0;
  logic CLK_SYS_I = 1'b0, RST_N_I = 1'b0, go = 1'b0;
  logic [1:0] gq = 2'h0;
  logic [8:0] gb = 9'h000;
  logic [7:0] glen = 8'h04;
  cmf_pkg::cmf_axi_req_t AXI_REQ_I = '0;
  cmf_pkg::cmf_axi_rsp_t AXI_RSP_O;
  logic DIR_TX_I = 1'b0, MASTER_SEL_I = 1'b1, ROT_EN_I = 1'b1, BYTE_ADJUST_I = 1'b0;
  logic BYTE_ORDER_FLIP_I = 1'b0, OUT_WIDTH_SELECT_I = 1'b0, STAT_EN_N_I = 1'b0;
  logic QBUS_DRIVE_EN_I = 1'b1, OUT_SIDE_ENABLE_I = 1'b1, OUT_CELL_AVAIL_I = 1'b0;
  logic MUX_LOAD_I = 1'b0, FIFO_SEL_LOW_I = 1'b0, FIFO_SEL_HIGH_I = 1'b0, CELL_END_WARN_I = 1'b0;
  logic [3:0] IN_SIDE_ENABLE_I = 4'h0, PER_QUEUE_CELL_READY_I = 4'h0;
  logic [3:0][8:0] IN_DATA_I;
  logic [3:0] IN_CELL_BEGIN_I, IN_CELL_AVAIL_I, IN_SIDE_ENABLE_O, IN_SIDE_ENABLE_OE_O;
  logic [3:0] IN_CELL_AVAIL_O, IN_CELL_AVAIL_OE_O, PER_QUEUE_CELL_READY_O;
  logic [3:0] PER_QUEUE_CELL_READY_OE_O;
  logic [17:0] OUT_BUS_O;
  logic OUT_BUS_OE_O, OUT_CELL_BEGIN_O, OUT_SIDE_ENABLE_O, OUT_SIDE_ENABLE_OE_O;
  logic OUT_CELL_AVAIL_O, OUT_CELL_AVAIL_OE_O, MUX_LOAD_O, MUX_LOAD_OE_O;
  logic FIFO_SEL_LOW_O, FIFO_SEL_LOW_OE_O, FIFO_SEL_HIGH_O, FIFO_SEL_HIGH_OE_O;
  logic CELL_END_WARN_O, CELL_END_WARN_OE_O;
  cmf_top dut (.*);
  cmf_cell_agent agent (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I), .go_i(go), .q_i(gq),
    .base_i(gb), .len_i(glen), .en_i(DIR_TX_I ? IN_SIDE_ENABLE_I : IN_SIDE_ENABLE_O),
    .data_o(IN_DATA_I), .begin_o(IN_CELL_BEGIN_I), .avail_o(IN_CELL_AVAIL_I));
  always #25 CLK_SYS_I = ~CLK_SYS_I;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // ready lines stay high, so no task re-raises them in the step it drops them
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    AXI_REQ_I.awaddr <= a;
    AXI_REQ_I.wdata <= d;
    AXI_REQ_I.wstrb <= 4'hF;
    AXI_REQ_I.awvalid <= 1'b1;
    AXI_REQ_I.wvalid <= 1'b1;
    do
    begin
      @(posedge CLK_SYS_I);
      if (AXI_RSP_O.awready) AXI_REQ_I.awvalid <= 1'b0;
      if (AXI_RSP_O.wready) AXI_REQ_I.wvalid <= 1'b0;
    end while (!AXI_RSP_O.bvalid);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    AXI_REQ_I.araddr <= a;
    AXI_REQ_I.arvalid <= 1'b1;
    do
    begin
      @(posedge CLK_SYS_I);
      if (AXI_RSP_O.arready) AXI_REQ_I.arvalid <= 1'b0;
    end while (!AXI_RSP_O.rvalid);
    d = AXI_RSP_O.rdata;
    r = AXI_RSP_O.rresp;
  endtask : axi_rd
  task automatic recv(input logic [1:0] q, input logic [8:0] b[$]);
    logic [17:0] w;
    int n;
    if (!OUT_WIDTH_SELECT_I && b.size() % 2) b.push_back(9'h000);
    n = OUT_WIDTH_SELECT_I ? b.size() : b.size() / 2;
    do @(negedge CLK_SYS_I); while (OUT_CELL_BEGIN_O !== 1'b1);
    `CHK("sel", q, {FIFO_SEL_HIGH_O, FIFO_SEL_LOW_O})
    `CHK("ready", 1'b1, PER_QUEUE_CELL_READY_O[q])
    for (int i = 0; i < n; i++)
    begin
      w = OUT_WIDTH_SELECT_I ? {9'h000, b[i]} :
        BYTE_ORDER_FLIP_I ? {b[2*i], b[2*i+1]} : {b[2*i+1], b[2*i]};
      `CHK("word", w, OUT_BUS_O)
      `CHK("begin", i == 0, OUT_CELL_BEGIN_O)
      `CHK("warn", i >= n - 2, CELL_END_WARN_O)
      `CHK("sending", 1'b1, OUT_SIDE_ENABLE_O)
      @(negedge CLK_SYS_I);
    end
    `CHK("warn end", 1'b0, CELL_END_WARN_O)
    @(negedge CLK_SYS_I);
    `CHK("ready end", 1'b0, PER_QUEUE_CELL_READY_O[q])
  endtask : recv
  task automatic run_cell(input logic [1:0] q, input logic [8:0] base, input logic [7:0] n);
    logic [8:0] b[$];
    for (int k = 0; k < int'(n); k++) b.push_back(base + 9'(k));
    if (BYTE_ADJUST_I && DIR_TX_I) b.delete(int'(cmf_pkg::DEL_POS));
    else if (BYTE_ADJUST_I) b.insert(int'(cmf_pkg::INS_POS), cmf_pkg::FILL_BYTE);
    @(posedge CLK_SYS_I);
    gq <= q;
    gb <= base;
    glen <= n;
    go <= 1'b1;
    @(posedge CLK_SYS_I);
    go <= 1'b0;
    recv(q, b);
  endtask : run_cell
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(cmf_pkg::REG_CTRL, d, r);
    `CHK("ctrl reset", cmf_pkg::CELL_LEN_RST, d[7:0])
    axi_rd(cmf_pkg::REG_STATUS, d, r);
    `CHK("no cell", 4'h0, d[3:0])
    axi_rd(8'h0C, d, r);
    `CHK("unmapped", cmf_pkg::RESP_DECERR, r)
    axi_wr(cmf_pkg::REG_CTRL, 32'h00000004);
    axi_rd(cmf_pkg::REG_CTRL, d, r);
    `CHK("ctrl", 8'h04, d[7:0])
    $display("test regs done");
  endtask : t_regs
  task automatic t_cells();
    for (int q = 0; q < 4; q++) run_cell(2'(q), 9'(16 * q + 1), 8'h04);
    @(posedge CLK_SYS_I);
    OUT_WIDTH_SELECT_I <= 1'b1;
    run_cell(2'h0, 9'h1A0, 8'h04);
    @(posedge CLK_SYS_I);
    OUT_WIDTH_SELECT_I <= 1'b0;
    BYTE_ORDER_FLIP_I <= 1'b1;
    BYTE_ADJUST_I <= 1'b1;
    axi_wr(cmf_pkg::REG_CTRL, 32'h00000006);
    run_cell(2'h1, 9'h150, 8'h06);
    $display("test cells done");
  endtask : t_cells
  task automatic t_modes();
    @(posedge CLK_SYS_I);
    DIR_TX_I <= 1'b1;
    ROT_EN_I <= 1'b0;
    MASTER_SEL_I <= 1'b0;
    STAT_EN_N_I <= 1'b1;
    QBUS_DRIVE_EN_I <= 1'b0;
    OUT_CELL_AVAIL_I <= 1'b1;
    MUX_LOAD_I <= 1'b1;
    FIFO_SEL_LOW_I <= 1'b1;
    FIFO_SEL_HIGH_I <= 1'b1;
    IN_SIDE_ENABLE_I <= 4'hF;
    repeat (2) @(posedge CLK_SYS_I);
    `CHK("room", 4'hF, IN_CELL_AVAIL_O & IN_CELL_AVAIL_OE_O)
    `CHK("sel dir", 1'b0, FIFO_SEL_HIGH_OE_O)
    `CHK("ready dir", 4'h0, PER_QUEUE_CELL_READY_OE_O)
    run_cell(2'h3, 9'h0F0, 8'h06);
    $display("test modes done");
  endtask : t_modes
  always @(posedge CLK_SYS_I)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    AXI_REQ_I.bready <= 1'b1;
    AXI_REQ_I.rready <= 1'b1;
    repeat (3) @(posedge CLK_SYS_I);
    RST_N_I <= 1'b1;
    t_regs();
    t_cells();
    t_modes();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
